// >>> core/setpoint_detect_output_update.sv
/*
 * Setpoint detection unit: sixteen setpoints compared against words of
 * the scan-rate acquisition stream, driving detect levels and updates of
 * the auxiliary digital port, a DAC or a timer. Classic Wishbone slave.
 * Assumes the stream comes from logic on clk_i, that each word carries
 * its setpoint index, and that counter words were latched at scan start.
 */
// Operation
// [RULE_01] Two 16-bit limits per setpoint.
// [RULE_02] Inside: below upper and above lower.
// [RULE_03] Outside: above upper or below lower.
// [RULE_04] Greater than: above lower limit only.
// [RULE_05] Less than: below upper limit only.
// [RULE_06] Equal: word equals upper limit.
// [RULE_07] Hysteresis: high forces first, low second.
// [RULE_08] Update modes: true only, both, none.
// [RULE_09] Both mode: true value, else false value.
// [RULE_10] Action: none, port, DAC or timer.
// [RULE_11] Port update writes byte through mask.
// [RULE_12] DAC update: 16-bit value, four outputs.
// [RULE_13] Timer update loads stored timer value.
// [RULE_14] Port is input until software writes it.
// [RULE_15] Evaluation starts as soon as armed.
// [RULE_16] Only scan-rate stream words are evaluated.
// [RULE_17] Counter setpoints see one 16-bit half.
// [RULE_18] Analog words evaluated two microseconds later.
// [RULE_19] Port changes together with detection.
// [RULE_20] DAC adds shift and conversion time.
// [RULE_21] DAC streaming may add pacer latency.
// [RULE_22] Sixteen setpoints, one per channel.
// [RULE_23] Detect follows criterion, once per scan.
// [RULE_24] Status word: bit n is setpoint n.
// [RULE_25] True-only: first value, nothing on false.
// [RULE_26] Last evaluated setpoint wins shared output.
`timescale 1ns/1ps
`default_nettype none

module setpoint_detect_output_update (
	// Clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// Wishbone slave
	input  wire logic [11:0]                adr_i,
	input  wire logic [31:0]                dat_i,
	output logic      [31:0]                dat_o,
	input  wire logic                       we_i,
	input  wire logic [3:0]                 sel_i,
	input  wire logic                       stb_i,
	input  wire logic                       cyc_i,
	output logic                            ack_o,
	// Acquisition stream
	input  wire setpoint_pkg::stream_word_t stream_i,
	// Detect levels
	output logic      [15:0]                detect_o,
	// Auxiliary digital port
	output logic      [7:0]                 aux_digital_port_o,
	output logic                            aux_digital_port_oe_o,
	// DAC and timer updates
	output setpoint_pkg::out_upd_t          analog_out_sel_o,
	output setpoint_pkg::out_upd_t          timer_out_sel_o
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam int ND = setpoint_pkg::QUEUE_DEPTH;
	localparam int NS = setpoint_pkg::NUM_SP;

	logic [31:0] lim_reg  [NS];
	logic [31:0] cfg_reg  [NS];
	logic [31:0] val_reg  [NS];
	logic        arm_reg;
	logic        ovf_reg;
	logic [15:0] detect_reg;
	logic [15:0] seen_reg;
	logic [7:0]  port_reg;
	logic        port_oe_reg;
	logic        ack_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	logic        q_valid_reg [ND];
	logic [3:0]  q_sp_reg    [ND];
	logic [15:0] q_data_reg  [ND];
	logic [7:0]  q_cnt_reg   [ND];

	logic        wr_en;
	logic        rd_en;
	logic        in_sp;
	logic [3:0]  reg_sp;
	logic [1:0]  reg_word;
	logic        arm_rise;
	logic        push;
	logic        pop;
	logic [1:0]  pop_idx;
	logic        free_ok;
	logic [1:0]  free_idx;
	logic [3:0]  ev_sp;
	logic [15:0] ev_word;
	setpoint_pkg::sp_cfg_t ev_cfg;
	logic        ev_det;
	logic        ev_fire;
	logic        ev_true;
	logic [15:0] ev_val;
	logic        ovf_set;
	logic        ovf_clr;
	logic [31:0] port_wr;

	// ****************************************************************
	// Bus decode
	// ****************************************************************

	// One access per request, answered on the next edge
	assign rd_en    = cyc_i && stb_i && !ack_reg && !we_i;
	assign wr_en    = cyc_i && stb_i && !ack_reg && we_i;
	assign in_sp    = adr_i >= setpoint_pkg::SP_BASE &&
	                  adr_i <= setpoint_pkg::SP_END;
	assign reg_sp   = adr_i[7:4];
	assign reg_word = adr_i[3:2];
	assign arm_rise = wr_en && adr_i == setpoint_pkg::CTRL_OFS && sel_i[0] &&
	                  dat_i[setpoint_pkg::CTRL_ARM_BIT] && !arm_reg;

	// Byte-lane merge under a writable-bit mask
	function automatic logic [31:0] merge(input logic [31:0] old_v,
	                                      input logic [31:0] new_v,
	                                      input logic [3:0]  be,
	                                      input logic [31:0] wmask);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
		merge = (old_v & ~m) | (new_v & m);
	endfunction

	// Acknowledge, dropped the cycle after it is given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= rd_en || wr_en;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_next = 32'h00000000;
		if (adr_i == setpoint_pkg::CTRL_OFS) begin
			rdata_next[setpoint_pkg::CTRL_ARM_BIT] = arm_reg;
			rdata_next[setpoint_pkg::CTRL_OVF_BIT] = ovf_reg;
		end else if (adr_i == setpoint_pkg::STATUS_OFS) begin
			rdata_next[15:0] = detect_reg; // [RULE_24]
		end else if (adr_i == setpoint_pkg::PORT_OFS) begin
			rdata_next[7:0] = port_reg;
			rdata_next[setpoint_pkg::PORT_OE_BIT] = port_oe_reg;
		end else if (in_sp) begin
			unique case (reg_word)
				setpoint_pkg::SP_LIM_WORD: rdata_next = lim_reg[reg_sp];
				setpoint_pkg::SP_CFG_WORD: rdata_next = cfg_reg[reg_sp];
				setpoint_pkg::SP_VAL_WORD: rdata_next = val_reg[reg_sp];
				default:                   rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= 32'h00000000;
		end else if (rd_en) begin
			rdata_reg <= rdata_next;
		end
	end

	// ****************************************************************
	// Control and setpoint registers
	// ****************************************************************

	// Arm bit; clearing it stops evaluation and drops queued words
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arm_reg <= setpoint_pkg::CTRL_RST[setpoint_pkg::CTRL_ARM_BIT];
		end else if (wr_en && adr_i == setpoint_pkg::CTRL_OFS && sel_i[0]) begin
			arm_reg <= dat_i[setpoint_pkg::CTRL_ARM_BIT]; // [RULE_15]
		end
	end

	// Sticky overflow of the pipeline queue, write one to clear
	assign ovf_clr = wr_en && adr_i == setpoint_pkg::CTRL_OFS && sel_i[0] &&
	                 dat_i[setpoint_pkg::CTRL_OVF_BIT];
	assign ovf_set = push && !free_ok;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovf_reg <= 1'b0;
		end else if (ovf_set) begin
			ovf_reg <= 1'b1;   // Set wins over a clear in the same cycle
		end else if (ovf_clr) begin
			ovf_reg <= 1'b0;
		end
	end

	// Setpoint tables, written during pre-acquisition setup
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NS; i++) begin
				lim_reg[i] <= setpoint_pkg::SP_RST;
				cfg_reg[i] <= setpoint_pkg::SP_RST;
				val_reg[i] <= setpoint_pkg::SP_RST;
			end
		end else if (wr_en && in_sp) begin
			unique case (reg_word)
				setpoint_pkg::SP_LIM_WORD: lim_reg[reg_sp] <=
					merge(lim_reg[reg_sp], dat_i, sel_i, 32'hffffffff); // [RULE_01]
				setpoint_pkg::SP_CFG_WORD: cfg_reg[reg_sp] <=
					merge(cfg_reg[reg_sp], dat_i, sel_i,
					      setpoint_pkg::CFG_WMASK);
				setpoint_pkg::SP_VAL_WORD: val_reg[reg_sp] <=
					merge(val_reg[reg_sp], dat_i, sel_i, 32'hffffffff);
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Pipeline queue
	// ****************************************************************

	// Only tagged stream words while armed; counter halves arrive as
	// ordinary 16-bit words, one setpoint each
	assign push = arm_reg && stream_i.valid && stream_i.has_sp; // [RULE_16] [RULE_17] [RULE_22]

	// Lowest-index search for a matured entry and for a free slot
	always_comb begin
		pop      = 1'b0;
		pop_idx  = 2'h0;
		free_ok  = 1'b0;
		free_idx = 2'h0;
		for (int i = ND - 1; i >= 0; i--) begin
			if (q_valid_reg[i] && q_cnt_reg[i] == 8'h00) begin
				pop     = 1'b1;
				pop_idx = 2'(i);
			end
			if (!q_valid_reg[i]) begin
				free_ok  = 1'b1;
				free_idx = 2'(i);
			end
		end
	end

	// Analog words wait out the converter pipeline; a full queue drops
	// the word, which only happens beyond the converter's rate
	always_ff @(posedge clk_i) begin
		if (rst_i || !arm_reg) begin
			for (int i = 0; i < ND; i++) begin
				q_valid_reg[i] <= 1'b0;
				q_sp_reg[i]    <= 4'h0;
				q_data_reg[i]  <= 16'h0000;
				q_cnt_reg[i]   <= 8'h00;
			end
		end else begin
			for (int i = 0; i < ND; i++) begin
				if (q_valid_reg[i] && q_cnt_reg[i] != 8'h00) begin
					q_cnt_reg[i] <= q_cnt_reg[i] - 8'h01; // [RULE_18]
				end
			end
			if (pop) begin
				q_valid_reg[pop_idx] <= 1'b0;
			end
			if (push && free_ok) begin
				q_valid_reg[free_idx] <= 1'b1;
				q_sp_reg[free_idx]    <= stream_i.sp;
				q_data_reg[free_idx]  <= stream_i.data;
				q_cnt_reg[free_idx]   <= stream_i.analog ?
					setpoint_pkg::ANALOG_LOAD :
					setpoint_pkg::DIRECT_LOAD; // [RULE_18]
			end
		end
	end

	// ****************************************************************
	// Evaluation
	// ****************************************************************
	assign ev_sp   = q_sp_reg[pop_idx];
	assign ev_word = q_data_reg[pop_idx];

	// Unpack the selected setpoint
	always_comb begin
		ev_cfg.limit_a   = lim_reg[ev_sp][setpoint_pkg::LIM_A_LSB +: 16];
		ev_cfg.limit_b   = lim_reg[ev_sp][setpoint_pkg::LIM_B_LSB +: 16];
		ev_cfg.crit      = setpoint_pkg::crit_t'(
			cfg_reg[ev_sp][setpoint_pkg::CFG_CRIT_LSB +: 3]);
		ev_cfg.upd       = setpoint_pkg::upd_t'(
			cfg_reg[ev_sp][setpoint_pkg::CFG_UPD_LSB +: 2]);
		ev_cfg.act       = setpoint_pkg::act_t'(
			cfg_reg[ev_sp][setpoint_pkg::CFG_ACT_LSB +: 2]);
		ev_cfg.sel       = cfg_reg[ev_sp][setpoint_pkg::CFG_SEL_LSB +: 2];
		ev_cfg.mask      = cfg_reg[ev_sp][setpoint_pkg::CFG_MASK_LSB +: 8];
		ev_cfg.val_true  = val_reg[ev_sp][setpoint_pkg::VAL_TRUE_LSB +: 16];
		ev_cfg.val_false = val_reg[ev_sp][setpoint_pkg::VAL_FALSE_LSB +: 16];
	end

	// One shared comparator; one word per cycle is all the stream gives
	setpoint_eval u_eval (
		.cfg_i      (ev_cfg),
		.word_i     (ev_word),
		.prev_i     (detect_reg[ev_sp]),
		.seen_i     (seen_reg[ev_sp]),
		.det_o      (ev_det),
		.fire_o     (ev_fire),
		.use_true_o (ev_true)
	);

	assign ev_val = ev_true ? ev_cfg.val_true : ev_cfg.val_false; // [RULE_09]

	// Detect levels, cleared at arming so a new acquisition starts fresh
	always_ff @(posedge clk_i) begin
		if (rst_i || arm_rise) begin
			detect_reg <= 16'h0000;
			seen_reg   <= 16'h0000;
		end else if (pop) begin
			detect_reg[ev_sp] <= ev_det; // [RULE_23] [RULE_24]
			seen_reg[ev_sp]   <= 1'b1;
		end
	end

	// ****************************************************************
	// Output updates
	// ****************************************************************

	// Software port write merged under byte lanes
	assign port_wr = merge({24'h000000, port_reg}, dat_i, sel_i,
	                       setpoint_pkg::PORT_WMASK);

	// Port: a software write enables drive; setpoints merge under mask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_reg    <= setpoint_pkg::PORT_RST;
			port_oe_reg <= 1'b0; // [RULE_14]
		end else if (pop && ev_fire && ev_cfg.act == setpoint_pkg::ACT_PORT) begin
			port_reg <= (port_reg & ~ev_cfg.mask) |
			            (ev_val[7:0] & ev_cfg.mask); // [RULE_11] [RULE_19]
		end else if (wr_en && adr_i == setpoint_pkg::PORT_OFS) begin
			port_reg <= port_wr[7:0]; // [RULE_14]
			if (sel_i[1]) begin
				port_oe_reg <= dat_i[setpoint_pkg::PORT_OE_BIT];
			end
		end
	end

	// DAC load strobe; shifting and conversion happen in the DAC path,
	// and a running DAC stream there can delay it by a pacer period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			analog_out_sel_o <= '0;
		end else begin
			analog_out_sel_o.load <= pop && ev_fire &&
				ev_cfg.act == setpoint_pkg::ACT_DAC; // [RULE_12] [RULE_20] [RULE_21]
			if (pop && ev_fire && ev_cfg.act == setpoint_pkg::ACT_DAC) begin
				analog_out_sel_o.sel   <= ev_cfg.sel; // [RULE_10] [RULE_26]
				analog_out_sel_o.value <= ev_val;
			end
		end
	end

	// Timer load strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_out_sel_o <= '0;
		end else begin
			timer_out_sel_o.load <= pop && ev_fire &&
				ev_cfg.act == setpoint_pkg::ACT_TIMER; // [RULE_13]
			if (pop && ev_fire && ev_cfg.act == setpoint_pkg::ACT_TIMER) begin
				timer_out_sel_o.sel   <= ev_cfg.sel; // [RULE_10] [RULE_26]
				timer_out_sel_o.value <= ev_val;
			end
		end
	end

	// ****************************************************************
	// Port wiring
	// ****************************************************************
	assign dat_o                 = rdata_reg;
	assign ack_o                 = ack_reg;
	assign detect_o              = detect_reg;
	assign aux_digital_port_o    = port_reg;
	assign aux_digital_port_oe_o = port_oe_reg;

endmodule

`default_nettype wire

// >>> include/setpoint_pkg.sv
/*
 * Shared constants and types of the setpoint detection unit: register map,
 * field positions, reset values, timing counts, mode codes and carriers.
 * Assumes a 100 MHz system clock and a 32-bit classic Wishbone bus.
 */
`default_nettype none
package setpoint_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int NUM_SP      = 16;
	localparam int SP_IDX_W    = 4;
	localparam int WORD_W      = 16;
	localparam int PORT_W      = 8;
	localparam int QUEUE_DEPTH = 4;
	localparam int ADR_W       = 12;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_FREQ_MHZ  = 100;
	localparam int PIPE_DELAY_NS = 2000;   // Converter pipeline delay
	localparam int PIPE_CYC      =
		(PIPE_DELAY_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int DLY_W         = 8;
	// Queue load values: a word is loaded one cycle after it arrives and its
	// result registered one cycle after its count reaches zero, so two are taken off here
	localparam logic [DLY_W-1:0] ANALOG_LOAD = DLY_W'(PIPE_CYC - 2);
	localparam logic [DLY_W-1:0] DIRECT_LOAD = 8'h00;

	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam logic [ADR_W-1:0] CTRL_OFS   = 12'h000;
	localparam logic [ADR_W-1:0] STATUS_OFS = 12'h004;
	localparam logic [ADR_W-1:0] PORT_OFS   = 12'h008;
	localparam logic [ADR_W-1:0] SP_BASE    = 12'h100;
	localparam logic [ADR_W-1:0] SP_END     = 12'h1ff;
	localparam logic [1:0]       SP_LIM_WORD = 2'h0;
	localparam logic [1:0]       SP_CFG_WORD = 2'h1;
	localparam logic [1:0]       SP_VAL_WORD = 2'h2;

	// ****************************************************************
	// Field positions and masks
	// ****************************************************************
	localparam int CTRL_ARM_BIT  = 0;
	localparam int CTRL_OVF_BIT  = 1;
	localparam int PORT_OE_BIT   = 8;
	localparam int LIM_A_LSB     = 16;
	localparam int LIM_B_LSB     = 0;
	localparam int CFG_CRIT_LSB  = 0;
	localparam int CFG_UPD_LSB   = 4;
	localparam int CFG_ACT_LSB   = 8;
	localparam int CFG_SEL_LSB   = 12;
	localparam int CFG_MASK_LSB  = 16;
	localparam int VAL_TRUE_LSB  = 0;
	localparam int VAL_FALSE_LSB = 16;
	localparam logic [31:0] CFG_WMASK  = 32'h00ff3337;
	localparam logic [31:0] PORT_WMASK = 32'h000001ff;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam logic [31:0] SP_RST   = 32'h00000000;
	localparam logic [7:0]  PORT_RST = 8'h00;

	// ****************************************************************
	// Mode codes
	// ****************************************************************
	typedef enum logic [2:0] {
		CRIT_INSIDE  = 3'b000,
		CRIT_OUTSIDE = 3'b001,
		CRIT_ABOVE   = 3'b010,   // Above low limit
		CRIT_BELOW   = 3'b011,   // Below high limit
		CRIT_EQUAL   = 3'b100,
		CRIT_HYST    = 3'b101
	} crit_t;

	typedef enum logic [1:0] {
		UPD_NONE = 2'b00,
		UPD_TRUE = 2'b01,
		UPD_BOTH = 2'b10
	} upd_t;

	typedef enum logic [1:0] {
		ACT_NONE  = 2'b00,
		ACT_PORT  = 2'b01,
		ACT_DAC   = 2'b10,
		ACT_TIMER = 2'b11
	} act_t;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic [WORD_W-1:0] limit_a;
		logic [WORD_W-1:0] limit_b;
		crit_t             crit;
		upd_t              upd;
		act_t              act;
		logic [1:0]        sel;
		logic [PORT_W-1:0] mask;
		logic [WORD_W-1:0] val_true;
		logic [WORD_W-1:0] val_false;
	} sp_cfg_t;

	typedef struct packed {
		logic                valid;
		logic                has_sp;
		logic                analog;
		logic [SP_IDX_W-1:0] sp;
		logic [WORD_W-1:0]   data;
	} stream_word_t;

	typedef struct packed {
		logic              load;
		logic [1:0]        sel;
		logic [WORD_W-1:0] value;
	} out_upd_t;

endpackage
`default_nettype wire

// >>> core/setpoint_eval.sv
/*
 * Combinational evaluation of one channel word against one setpoint:
 * new detect level, whether an update fires, and which value it uses.
 * Assumes the caller registers the results and keeps per-setpoint state.
 */
`timescale 1ns/1ps
`default_nettype none

module setpoint_eval (
	// Setpoint and word
	input  wire setpoint_pkg::sp_cfg_t  cfg_i,
	input  wire logic [15:0]            word_i,
	// Previous state of this setpoint
	input  wire logic                   prev_i,
	input  wire logic                   seen_i,
	// Results
	output logic                        det_o,
	output logic                        fire_o,
	output logic                        use_true_o
);

	logic above_a;
	logic below_a;
	logic above_b;
	logic below_b;
	logic changed;

	// Strict comparisons on both limits
	assign above_a = word_i > cfg_i.limit_a;
	assign below_a = word_i < cfg_i.limit_a;
	assign above_b = word_i > cfg_i.limit_b;
	assign below_b = word_i < cfg_i.limit_b;

	// Criterion select
	always_comb begin
		unique case (cfg_i.crit)
			setpoint_pkg::CRIT_INSIDE:  det_o = below_a && above_b; // [RULE_02]
			setpoint_pkg::CRIT_OUTSIDE: det_o = above_a || below_b; // [RULE_03]
			setpoint_pkg::CRIT_ABOVE:   det_o = above_b;            // [RULE_04]
			setpoint_pkg::CRIT_BELOW:   det_o = below_a;            // [RULE_05]
			setpoint_pkg::CRIT_EQUAL:   det_o = word_i == cfg_i.limit_a; // [RULE_06]
			// Inside the window the level holds
			setpoint_pkg::CRIT_HYST:
				det_o = above_a ? 1'b1 : (below_b ? 1'b0 : prev_i); // [RULE_07]
			default: det_o = 1'b0;
		endcase
	end

	// First evaluation after arming always counts as a change
	assign changed = !seen_i || (det_o != prev_i); // [RULE_23]
	assign use_true_o = det_o;

	// Update decision, edge based so the latest met criterion wins
	always_comb begin
		if (cfg_i.crit == setpoint_pkg::CRIT_HYST) begin
			fire_o = changed && (above_a || below_b); // [RULE_07]
		end else begin
			unique case (cfg_i.upd)
				setpoint_pkg::UPD_TRUE: fire_o = changed && det_o; // [RULE_25]
				setpoint_pkg::UPD_BOTH: fire_o = changed;          // [RULE_09]
				default:                fire_o = 1'b0;             // [RULE_08]
			endcase
		end
	end

endmodule

`default_nettype wire

// >>> tb/scan_source.sv
/* Far-side model: the scan stream that feeds the setpoint unit.
   Assumes requests from the bench on clk_i, one word per request. */
`timescale 1ns/1ps
`default_nettype none
module scan_source (
	// Clock and request
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  req_i,
	input  wire logic                  analog_i,
	input  wire logic [3:0]            sp_i,
	input  wire logic [31:0]           count_i,
	// Stream to the unit
	output setpoint_pkg::stream_word_t stream_o
);
	// One word per scan slot; idle data toggles so stale words never match
	always_ff @(posedge clk_i) begin
		stream_o.valid  <= req_i & ~rst_i;
		stream_o.has_sp <= req_i;
		stream_o.analog <= analog_i;
		stream_o.sp     <= sp_i;
		if (req_i) begin
			stream_o.data <= count_i[15:0];
		end else begin
			stream_o.data <= rst_i ? 16'h5a5a : ~stream_o.data;
		end
	end
endmodule
`default_nettype wire

// >>> tb/setpoint_checker.sv
/* Port checker of the setpoint unit.
   Assumes it is bound to the top module; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module setpoint_checker (
	// Clock, reset and bus
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire logic [11:0]            adr_i,
	input wire logic [31:0]            dat_o,
	input wire logic                   we_i,
	input wire logic                   stb_i,
	input wire logic                   cyc_i,
	input wire logic                   ack_o,
	// Stream and outputs
	input wire setpoint_pkg::stream_word_t stream_i,
	input wire logic [15:0]            detect_o,
	input wire logic [7:0]             aux_digital_port_o,
	input wire logic                   aux_digital_port_oe_o,
	input wire setpoint_pkg::out_upd_t analog_out_sel_o,
	input wire setpoint_pkg::out_upd_t timer_out_sel_o
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence req_s;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence rd_s;
		req_s ##0 !we_i && adr_i == setpoint_pkg::STATUS_OFS;
	endsequence
	ack_resp_a: assert property (req_s |=> ack_o)
		else $error("bus request not answered");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	status_read_a: assert property (
		rd_s |=> dat_o == {16'h0000, $past(detect_o)})
		else $error("status word differs from detect");
	reset_out_a: assert property ($fell(rst_i) |->
		!aux_digital_port_oe_o && detect_o == 16'h0000)
		else $error("port or detect active after reset");
	dac_pulse_a: assert property (analog_out_sel_o.load |=>
		!analog_out_sel_o.load && $stable(analog_out_sel_o.value))
		else $error("converter load not a held pulse");
	tmr_pulse_a: assert property (timer_out_sel_o.load |=>
		!timer_out_sel_o.load && $stable(timer_out_sel_o.value))
		else $error("timer load not a held pulse");
	port_cause_a: assert property ($changed(aux_digital_port_o) |->
		ack_o || $past(stream_i.valid, 2) || $past(stream_i.valid, 200))
		else $error("port changed without cause");
	det_cause_a: assert property ($changed(detect_o) |-> ack_o ||
		$past(ack_o) || $past(stream_i.valid, 2) ||
		$past(stream_i.valid, 200))
		else $error("detect changed without a word");
endmodule
bind setpoint_detect_output_update setpoint_checker CHK (.clk_i, .rst_i,
	.adr_i, .dat_o, .we_i, .stb_i, .cyc_i, .ack_o, .stream_i, .detect_o,
	.aux_digital_port_o, .aux_digital_port_oe_o, .analog_out_sel_o,
	.timer_out_sel_o);
`default_nettype wire

// >>> tb/test_setpoint_detect_output_update.sv
/* Bench of the setpoint unit: bus tasks, scan source, reference model.
   Assumes the package, design and scan source are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_setpoint_detect_output_update;
	localparam logic [15:0] LA = 16'h8000;
	localparam logic [15:0] LB = 16'h4000;
	logic        clk_i, rst_i, we_i, stb_i, cyc_i, ack_o, req, ana;
	logic [11:0] adr_i;
	logic [31:0] dat_i, dat_o, rd, cnt;
	logic [3:0]  sel_i, spn;
	logic [15:0] detect_o, st, vt[10], vf[10], pk[5];
	logic [7:0]  aux_digital_port_o, mk[10];
	logic        aux_digital_port_oe_o;
	setpoint_pkg::stream_word_t stream_i;
	setpoint_pkg::out_upd_t     analog_out_sel_o, timer_out_sel_o;
	int err_count, checks, port, det[10], seen[10];
	int ct[10] = '{0, 1, 2, 3, 4, 5, 3, 1, 2, 0};
	int ut[10] = '{2, 2, 2, 2, 2, 2, 1, 2, 0, 1};
	int at[10] = '{1, 1, 1, 0, 1, 1, 2, 3, 1, 1};
	setpoint_detect_output_update DUT (.clk_i, .rst_i, .adr_i, .dat_i,
		.dat_o, .we_i, .sel_i, .stb_i, .cyc_i, .ack_o, .stream_i,
		.detect_o, .aux_digital_port_o, .aux_digital_port_oe_o,
		.analog_out_sel_o, .timer_out_sel_o);
	scan_source SRC (.clk_i, .rst_i, .req_i(req), .analog_i(ana),
		.sp_i(spn), .count_i(cnt), .stream_o(stream_i));
	// 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Classic cycle; a missing ack ends the run rather than hanging it
	task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
		int n;
		n = 0;
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		do begin
			@(posedge clk_i);
			n++;
			if (n > 20) begin
				err_count++;
				stop_test();
			end
		end while (ack_o !== 1'b1);
		rd = dat_o;
		{cyc_i, stb_i} <= 2'b00;
		@(posedge clk_i);
	endtask
	task automatic cfg(int s);
		vt[s] = 16'($urandom());
		vf[s] = 16'($urandom());
		mk[s] = 8'hff >> (s % 8);
		bus(1'b1, 12'h100 + 12'(16 * s), {LA, LB});
		bus(1'b1, 12'h104 + 12'(16 * s), {8'h00, mk[s], 2'b00, 2'(s),
			2'b00, 2'(at[s]), 2'b00, 2'(ut[s]), 1'b0, 3'(ct[s])});
		bus(1'b1, 12'h108 + 12'(16 * s), {vf[s], vt[s]});
	endtask
	// One word through the source; analog words wait out the pipeline
	task automatic word(int s, logic [15:0] x);
		int nd, f;
		logic [15:0] v;
		{spn, cnt, ana, req} <= {4'(s), 16'($urandom()), x, s == 6, 1'b1};
		@(posedge clk_i);
		req <= 1'b0;
		case (ct[s])
			0: nd = x < LA && x > LB;
			1: nd = x > LA || x < LB;
			2: nd = x > LB;
			3: nd = x < LA;
			4: nd = x == LA;
			default: nd = x > LA ? 1 : x < LB ? 0 : det[s];
		endcase
		f = nd != det[s] || !seen[s];
		f = ct[s] == 5 ? f && (x > LA || x < LB) :
			f && (ut[s] == 2 || ut[s] == 1 && nd);
		v = nd ? vt[s] : vf[s];
		repeat (s == 6 ? 199 : 1) @(posedge clk_i);
		#1;
		chk("early", detect_o[s], det[s]);
		@(posedge clk_i);
		#1;
		if (f && at[s] == 1) port = port & ~mk[s] | v[7:0] & mk[s];
		det[s] = nd;
		seen[s] = 1;
		chk("detect", detect_o[s], nd);
		chk("port", aux_digital_port_o, port);
		chk("dac", analog_out_sel_o.load, f && at[s] == 2);
		chk("timer", timer_out_sel_o.load, f && at[s] == 3);
		if (f && at[s] > 1) chk("value", at[s] == 2 ? analog_out_sel_o :
			timer_out_sel_o, {1'b1, 2'(s), v});
		@(posedge clk_i);
	endtask
	// Main sequence
	initial begin
		{rst_i, cyc_i, stb_i, we_i, req, ana} = 6'h20;
		{adr_i, dat_i, sel_i, spn, cnt} = {12'h000, 32'h0, 4'hf, 4'h0, 32'h0};
		err_count = 0;
		checks = 0;
		port = 0;
		void'($urandom(85));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, 12'h008, 32'h0);
		chk("port reg", rd, 32'h0);
		bus(1'b0, 12'h010, 32'h0);
		chk("unmapped", rd, 32'h0);
		bus(1'b1, 12'h008, 32'h15a);
		port = 'h5a;
		chk("drive", {aux_digital_port_oe_o, aux_digital_port_o}, 'h15a);
		for (int s = 0; s < 10; s++) cfg(s);
		bus(1'b1, 12'h000, 32'h1);
		pk = '{LA, LB, LA + 16'h1, LB - 16'h1, 16'h0};
		for (int j = 0; j < 60; j++) begin
			pk[4] = 16'($urandom());
			word(j % 10, j == 5 ? 16'hffff : pk[$urandom() % 5]);
		end
		st = 16'h0000;
		for (int s = 0; s < 10; s++) st[s] = det[s] != 0;
		bus(1'b0, 12'h000, 32'h0);
		chk("ctrl", rd, 32'h1);
		bus(1'b0, 12'h004, 32'h0);
		chk("status", rd, {16'h0000, st});
		stop_test();
	end
endmodule
`default_nettype wire
